//--- logic/pcaer_pkg.sv
// constants for the error reporting capability register set
package pcaer_pkg;
	// placement of the structure in extended configuration space
	localparam logic [11:0] PCAER_BASE = 12'h100;
	localparam logic [11:0] PCAER_SPAN = 12'h018;
	// register offsets within the structure
	localparam logic [11:0] PCAER_OFF_HDR = 12'h000;
	localparam logic [11:0] PCAER_OFF_UNC_STA = 12'h004;
	localparam logic [11:0] PCAER_OFF_UNC_MSK = 12'h008;
	localparam logic [11:0] PCAER_OFF_UNC_SEV = 12'h00C;
	localparam logic [11:0] PCAER_OFF_COR_STA = 12'h010;
	localparam logic [11:0] PCAER_OFF_COR_MSK = 12'h014;
	// header fields
	localparam logic [15:0] PCAER_CAP_ID = 16'h0001;
	localparam logic [3:0] PCAER_CAP_VER = 4'h1;
	localparam logic [11:0] PCAER_NEXT_SN = 12'h140;
	localparam logic [11:0] PCAER_NEXT_END = 12'h000;
	// uncorrectable bit positions
	localparam int PCAER_UNC_DLP = 4;
	localparam int PCAER_UNC_POISON = 12;
	localparam int PCAER_UNC_FCP = 13;
	localparam int PCAER_UNC_CPL_TO = 14;
	localparam int PCAER_UNC_CPL_ABT = 15;
	localparam int PCAER_UNC_UNEXP = 16;
	localparam int PCAER_UNC_RX_OVF = 17;
	localparam int PCAER_UNC_MALF = 18;
	localparam int PCAER_UNC_UNSUP = 20;
	// correctable bit positions
	localparam int PCAER_COR_RX_ERR = 0;
	localparam int PCAER_COR_BAD_TLP = 6;
	localparam int PCAER_COR_BAD_DLLP = 7;
	localparam int PCAER_COR_RPL_ROLL = 8;
	localparam int PCAER_COR_RPL_TO = 12;
	localparam int PCAER_COR_ADVIS = 13;
	// implemented-bit masks and reset values
	localparam logic [31:0] PCAER_UNC_IMPL = 32'h0017F010;
	localparam logic [31:0] PCAER_UNC_STA_RST = 32'h00000000;
	localparam logic [31:0] PCAER_UNC_MSK_RST = 32'h00000000;
	localparam logic [31:0] PCAER_UNC_SEV_RST = 32'h00062010;
	localparam logic [31:0] PCAER_COR_IMPL = 32'h000031C1;
	localparam logic [31:0] PCAER_COR_STA_RST = 32'h00000000;
	localparam logic [31:0] PCAER_COR_MSK_RST = 32'h00002000;
endpackage

//--- logic/pcaer_regs.sv
// error reporting capability registers with sticky status, mask and severity
// Behaviour
// - header bits 15:0 always read the fixed capability identifier 0x0001
// - header bits 19:16 read constant version one, writes ignored
// - next pointer reads 0x140 if serial number enabled, else 0x000
// - uncorrectable status bit sets on its error, holds, clears on write one
// - uncorrectable bits 4,12,13,14: link protocol, poisoned, flow control, timeout
// - bits 15..18,20 abort, unexpected, overflow, malformed, unsupported; rest read zero
// - one mask bit per uncorrectable status bit; set mask suppresses message
// - uncorrectable mask bits reset to zero
// - unmasked uncorrectable error reported fatal if severity one, else non-fatal
// - severity resets with bits 4,13,17,18 set, others clear
// - correctable status bit sets on error, holds, clears on write one
// - correctable bits 0,6,7,8,12,13: receiver, bad TLP, bad DLLP, rollover, replay timeout, advisory; reserved read zero
// - set correctable mask bit suppresses that error's message
// - correctable mask resets with only bit 13 set
// - structure sits at extended configuration offset 0x100
`timescale 1ns/1ps
module pcaer_regs
	import pcaer_pkg::*;
(
	// clock and power-up reset
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	// hot or function-level reset, synchronous to ref_clk_in
	input wire logic hot_rst_in,
	// configuration access port
	input wire logic cfg_req_in,
	input wire logic cfg_we_in,
	input wire logic [11:0] cfg_addr_in,
	input wire logic [3:0] cfg_be_in,
	input wire logic [31:0] cfg_wdata_in,
	output logic cfg_ack_out,
	output logic [31:0] cfg_rdata_out,
	// loaded configuration
	input wire logic nvm_sn_en_in,
	// error detection pulses, one bit per status position
	input wire logic [31:0] unc_err_in,
	input wire logic [31:0] cor_err_in,
	// error message requests toward the link
	output logic msg_cor_out,
	output logic msg_nonfatal_out,
	output logic msg_fatal_out
);

	logic [31:0] unc_sta;
	logic [31:0] unc_msk;
	logic [31:0] unc_sev;
	logic [31:0] cor_sta;
	logic [31:0] cor_msk;
	logic [31:0] next_unc_sta;
	logic [31:0] next_unc_msk;
	logic [31:0] next_unc_sev;
	logic [31:0] next_cor_sta;
	logic [31:0] next_cor_msk;

	logic cfg_ack;
	logic [31:0] cfg_rdata;
	logic msg_cor;
	logic msg_nonfatal;
	logic msg_fatal;
	logic next_cfg_ack;
	logic [31:0] next_cfg_rdata;
	logic next_msg_cor;
	logic next_msg_nonfatal;
	logic next_msg_fatal;

	logic [11:0] rel_addr;
	logic in_cap;
	logic wr;
	logic [31:0] be_bits;
	logic [31:0] unc_evt;
	logic [31:0] cor_evt;
	logic [31:0] hdr;

	// byte lanes widened to a bit mask
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_be
			assign be_bits[gi*8 +: 8] = {8{cfg_be_in[gi]}};
		end
	endgenerate

	// decode against the structure base; unsigned wrap keeps low addresses out
	assign rel_addr = cfg_addr_in - PCAER_BASE;
	assign in_cap = (cfg_addr_in >= PCAER_BASE) && (rel_addr < PCAER_SPAN);
	assign wr = cfg_req_in && cfg_we_in && in_cap;

	// only implemented sources may ever reach a status bit
	assign unc_evt = unc_err_in & PCAER_UNC_IMPL;
	assign cor_evt = cor_err_in & PCAER_COR_IMPL;

	// header is pure wiring: no storage, writes have nothing to land in
	assign hdr = {(nvm_sn_en_in ? PCAER_NEXT_SN : PCAER_NEXT_END),
		PCAER_CAP_VER,
		PCAER_CAP_ID};

	// sticky register group
	always_comb begin
		logic [31:0] w1c;
		logic [31:0] wsel;
		w1c = cfg_wdata_in & be_bits;
		wsel = be_bits;
		next_unc_sta = unc_sta;
		next_unc_msk = unc_msk;
		next_unc_sev = unc_sev;
		next_cor_sta = cor_sta;
		next_cor_msk = cor_msk;
		if (wr) begin
			unique case ({rel_addr[11:2], 2'b00})
				PCAER_OFF_UNC_STA: begin
					next_unc_sta = unc_sta & ~w1c;
				end
				PCAER_OFF_UNC_MSK: begin
					next_unc_msk = ((unc_msk & ~wsel) | (cfg_wdata_in & wsel))
						& PCAER_UNC_IMPL;
				end
				PCAER_OFF_UNC_SEV: begin
					next_unc_sev = ((unc_sev & ~wsel) | (cfg_wdata_in & wsel))
						& PCAER_UNC_IMPL;
				end
				PCAER_OFF_COR_STA: begin
					next_cor_sta = cor_sta & ~w1c;
				end
				PCAER_OFF_COR_MSK: begin
					next_cor_msk = ((cor_msk & ~wsel) | (cfg_wdata_in & wsel))
						& PCAER_COR_IMPL;
				end
				default: begin
				end
			endcase
		end
		// a new error in the clearing cycle survives the clear
		next_unc_sta = next_unc_sta | unc_evt;
		next_cor_sta = next_cor_sta | cor_evt;
	end

	// power-up reset only: hot reset must not wipe logged errors
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			unc_sta <= PCAER_UNC_STA_RST;
			unc_msk <= PCAER_UNC_MSK_RST;
			unc_sev <= PCAER_UNC_SEV_RST;
			cor_sta <= PCAER_COR_STA_RST;
			cor_msk <= PCAER_COR_MSK_RST;
		end else begin
			unc_sta <= next_unc_sta;
			unc_msk <= next_unc_msk;
			unc_sev <= next_unc_sev;
			cor_sta <= next_cor_sta;
			cor_msk <= next_cor_msk;
		end
	end

	// access answer and message group, cleared by either reset
	always_comb begin
		logic [31:0] rd;
		logic [31:0] unc_live;
		logic [31:0] cor_live;
		rd = 32'h00000000;
		unc_live = unc_evt & ~unc_msk;
		cor_live = cor_evt & ~cor_msk;
		if (in_cap) begin
			unique case ({rel_addr[11:2], 2'b00})
				PCAER_OFF_HDR: rd = hdr;
				PCAER_OFF_UNC_STA: rd = unc_sta;
				PCAER_OFF_UNC_MSK: rd = unc_msk;
				PCAER_OFF_UNC_SEV: rd = unc_sev;
				PCAER_OFF_COR_STA: rd = cor_sta;
				PCAER_OFF_COR_MSK: rd = cor_msk;
				default: rd = 32'h00000000;
			endcase
		end
		next_cfg_ack = cfg_req_in;
		next_cfg_rdata = (cfg_req_in && !cfg_we_in) ? rd : 32'h00000000;
		next_msg_fatal = |(unc_live & unc_sev);
		next_msg_nonfatal = |(unc_live & ~unc_sev);
		next_msg_cor = |cor_live;
		if (hot_rst_in) begin
			next_cfg_ack = 1'b0;
			next_cfg_rdata = 32'h00000000;
			next_msg_fatal = 1'b0;
			next_msg_nonfatal = 1'b0;
			next_msg_cor = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cfg_ack <= 1'b0;
			cfg_rdata <= 32'h00000000;
			msg_cor <= 1'b0;
			msg_nonfatal <= 1'b0;
			msg_fatal <= 1'b0;
		end else begin
			cfg_ack <= next_cfg_ack;
			cfg_rdata <= next_cfg_rdata;
			msg_cor <= next_msg_cor;
			msg_nonfatal <= next_msg_nonfatal;
			msg_fatal <= next_msg_fatal;
		end
	end

	assign cfg_ack_out = cfg_ack;
	assign cfg_rdata_out = cfg_rdata;
	assign msg_cor_out = msg_cor;
	assign msg_nonfatal_out = msg_nonfatal;
	assign msg_fatal_out = msg_fatal;

endmodule

//--- sim/pcaer_regs_props.sv
// port assertions for the error reporting register set
`timescale 1ns/1ps
module pcaer_regs_props (
	// clock and resets
	input wire logic ref_clk_in, rstn_in, hot_rst_in,
	// configuration access
	input wire logic cfg_req_in, cfg_we_in, cfg_ack_out,
	input wire logic [11:0] cfg_addr_in,
	input wire logic [3:0] cfg_be_in,
	input wire logic [31:0] cfg_wdata_in, cfg_rdata_out,
	// errors and messages
	input wire logic nvm_sn_en_in, msg_cor_out, msg_nonfatal_out, msg_fatal_out,
	input wire logic [31:0] unc_err_in, cor_err_in
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rstn_in);
	sequence take;
		cfg_req_in && !hot_rst_in;
	endsequence
	sequence hdr_rd;
		take ##0 (!cfg_we_in && cfg_addr_in[11:2] == 10'h040);
	endsequence
	sequence sta_rd;
		take ##0 (!cfg_we_in && cfg_addr_in[11:2] == 10'h041);
	endsequence
	chk_ack_follows: assert property (take |=> cfg_ack_out)
		else $error("request not acknowledged");
	chk_ack_cause: assert property (cfg_ack_out |-> $past(cfg_req_in) && !$past(hot_rst_in))
		else $error("acknowledge without request");
	chk_rdata_idle: assert property (!cfg_ack_out |-> cfg_rdata_out == 32'h0)
		else $error("read data outside acknowledge");
	chk_hdr_fixed: assert property (hdr_rd |=> cfg_rdata_out[19:0] == 20'h10001)
		else $error("header identifier or version wrong");
	chk_next_ptr: assert property (hdr_rd |=>
		cfg_rdata_out[31:20] == ($past(nvm_sn_en_in) ? 12'h140 : 12'h000))
		else $error("next pointer wrong");
	chk_unc_rsvd: assert property (sta_rd |=> (cfg_rdata_out & ~32'h0017F010) == 32'h0)
		else $error("reserved status bits set");
	chk_fatal_cause: assert property (msg_fatal_out |-> $past(|(unc_err_in & 32'h0017F010)))
		else $error("fatal message without error");
	chk_cor_cause: assert property (msg_cor_out |-> $past(|(cor_err_in & 32'h000031C1)))
		else $error("correctable message without error");
	chk_hot_quiet: assert property (hot_rst_in |=>
		!(cfg_ack_out || msg_cor_out || msg_nonfatal_out || msg_fatal_out))
		else $error("outputs active after hot reset");
endmodule
bind pcaer_regs pcaer_regs_props props (.*);

//--- sim/pcaer_host.sv
// far-side model that counts error messages per class
`timescale 1ns/1ps
module pcaer_host (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	// message requests from the device
	input wire logic cor_in,
	input wire logic nf_in,
	input wire logic fat_in,
	// running counts
	output logic [23:0] cnt_out
);
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cnt_out <= '0;
		end else begin
			cnt_out <= cnt_out + {7'h0, cor_in, 7'h0, nf_in, 7'h0, fat_in};
		end
	end
endmodule

//--- sim/pcaer_regs_bench.sv
// self-checking bench for the error reporting register set
`timescale 1ns/1ps
module pcaer_regs_bench;
	logic ref_clk_in = 0, rstn_in = 0, hot_rst_in = 0, cfg_req_in = 0, cfg_we_in = 0;
	logic nvm_sn_en_in = 0, cfg_ack_out, msg_cor_out, msg_nonfatal_out, msg_fatal_out;
	logic [11:0] cfg_addr_in = '0;
	logic [3:0] cfg_be_in = '0;
	logic [31:0] cfg_wdata_in = '0, unc_err_in = '0, cor_err_in = '0, cfg_rdata_out, rd;
	logic [23:0] cnt;
	int n_fail = 0, compares = 0;
	always #50 ref_clk_in = ~ref_clk_in;
	pcaer_regs uut (.*);
	pcaer_host host (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .cor_in(msg_cor_out),
		.nf_in(msg_nonfatal_out), .fat_in(msg_fatal_out), .cnt_out(cnt));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task acc(input logic we, input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
		@(negedge ref_clk_in);
		{cfg_req_in, cfg_we_in, cfg_addr_in, cfg_be_in, cfg_wdata_in} = {1'b1, we, a, be, d};
		@(negedge ref_clk_in);
		cfg_req_in = 0;
		for (int i = 0; i < 3 && cfg_ack_out !== 1'b1; i++) @(negedge ref_clk_in);
		rd = cfg_rdata_out;
	endtask
	task rdchk(input logic [11:0] a, input logic [31:0] e);
		acc(0, a, 4'hF, 32'h0);
		chk({31'h0, cfg_ack_out}, 32'h1);
		chk(rd, e);
	endtask
	task pulse(input logic [31:0] u, input logic [31:0] c);
		@(negedge ref_clk_in);
		{unc_err_in, cor_err_in} = {u, c};
		@(negedge ref_clk_in);
		{unc_err_in, cor_err_in} = '0;
		repeat (2) @(negedge ref_clk_in);
	endtask
	task t_reset;
		rdchk(12'h100, 32'h00010001);
		nvm_sn_en_in = 1;
		rdchk(12'h100, 32'h14010001);
		rdchk(12'h104, 32'h0);
		rdchk(12'h108, 32'h0);
		rdchk(12'h10C, 32'h00062010);
		rdchk(12'h114, 32'h00002000);
	endtask
	task t_rw;
		for (int a = 0; a < 6; a++) acc(1, 12'h100 + 12'(4 * a), 4'hF, '1);
		rdchk(12'h100, 32'h14010001);
		rdchk(12'h108, 32'h0017F010);
		rdchk(12'h10C, 32'h0017F010);
		rdchk(12'h114, 32'h000031C1);
		rdchk(12'h118, 32'h0);
	endtask
	task t_masked;
		pulse('1, '1);
		chk(cnt, 0);
		rdchk(12'h104, 32'h0017F010);
		rdchk(12'h110, 32'h000031C1);
		hot_rst_in = 1;
		@(negedge ref_clk_in);
		hot_rst_in = 0;
		rdchk(12'h108, 32'h0017F010);
		acc(1, 12'h104, 4'h1, '1);
		rdchk(12'h104, 32'h0017F000);
		acc(1, 12'h110, 4'h0, '1);
		rdchk(12'h110, 32'h000031C1);
		acc(1, 12'h110, 4'hF, '1);
		rdchk(12'h110, 32'h0);
	endtask
	task t_sev;
		acc(1, 12'h108, 4'hF, 32'h0);
		acc(1, 12'h10C, 4'hF, 32'h10);
		acc(1, 12'h114, 4'hF, 32'h0);
		pulse(32'h10, 32'h0);
		chk(cnt, 24'h000001);
		pulse(32'h1000, 32'h1);
		chk(cnt, 24'h010101);
		pulse(32'h00100010, 32'h0);
		chk(cnt, 24'h010202);
		acc(1, 12'h114, 4'hF, 32'h1);
		pulse(32'h0, 32'h1);
		chk(cnt, 24'h010202);
	endtask
	task print_verdict;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#200000;
		n_fail++;
		print_verdict;
	end
	initial begin
		repeat (16) @(posedge ref_clk_in);
		@(negedge ref_clk_in);
		rstn_in = 1;
		t_reset;
		t_rw;
		t_masked;
		t_sev;
		print_verdict;
	end
endmodule
